// ---- sfesv_pkg.sv ----
package sfesv_pkg;

    ////////////////////////////////////////////////////////////////////////
    // video sample format
    localparam int VID_W = 10;
    localparam logic [9:0] VID_MAX = 10'h3FF;
    localparam logic [9:0] VID_ZERO = 10'h000;

    // line geometry kept in flops
    localparam int PIX = 16;
    localparam int PIX_W = 4;
    localparam logic [3:0] PIX_LAST = 4'hF;

    // colour line spacing at unity magnification
    localparam logic [15:0] GAP_LINES = 16'h0004;
    localparam logic [15:0] MAG_UNITY = 16'h0064;
    localparam logic [15:0] MAG_HALF = 16'h0032;
    localparam logic [2:0] MAX_DLY = 3'h4;
    localparam int DEPTH = 9;
    localparam logic [4:0] DEPTH_V = 5'h09;
    localparam logic [3:0] LP_LAST = 4'h8;

    // output buffer
    localparam int FIFO_DEPTH = 4;

    ////////////////////////////////////////////////////////////////////////
    // sensor patterns {l3,l2,l1,w2,w1}, 1 = paper present
    localparam logic [4:0] PAT_A3 = 5'h1F;
    localparam logic [4:0] PAT_B4 = 5'h1D;
    localparam logic [4:0] PAT_F4 = 5'h1C;
    localparam logic [4:0] PAT_A4L = 5'h0C;
    localparam logic [4:0] PAT_B5L = 5'h04;
    localparam logic [4:0] PAT_A4S = 5'h03;
    localparam logic [4:0] PAT_B5S = 5'h01;
    localparam logic [4:0] PAT_NONE = 5'h00;

    // size codes
    localparam logic [7:0] CODE_A3 = 8'h84;
    localparam logic [7:0] CODE_B4 = 8'h8D;
    localparam logic [7:0] CODE_F4 = 8'hA5;
    localparam logic [7:0] CODE_A4L = 8'h85;
    localparam logic [7:0] CODE_B5L = 8'h8E;
    localparam logic [7:0] CODE_A4S = 8'h05;
    localparam logic [7:0] CODE_B5S = 8'h0E;
    localparam logic [7:0] CODE_A5 = 8'h80;
    localparam logic [7:0] CODE_UNDET = 8'h00;

    // synchroniser bit positions
    localparam int SYNC_W = 8;
    localparam int SY_COVER = 5;
    localparam int SY_START = 6;
    localparam int SY_SMALL = 7;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [9:0] r;
        logic [9:0] g;
        logic [9:0] b;
    } sfesv_pix_type;

    typedef struct packed {
        logic [7:0] code;
        logic unknown;
        logic valid;
    } sfesv_size_type;

endpackage

// ---- sfesv_sync.sv ----
`timescale 1ns/1ps
module sfesv_sync #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // pins
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] stable;
    } sfesv_sync_type;

    sfesv_sync_type q;
    sfesv_sync_type next_q;
    logic [W-1:0] agree;

    ////////////////////////////////////////////////////////////////////////
    // s1 feeds only s2; a bit changes once s2 and s3 agree
    always_comb begin
        agree = ~(q.s2 ^ q.s3);
        next_q = q;
        next_q.s1 = d_in;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.stable = (q.s2 & agree) | (q.stable & ~agree);
    end

    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign q_out = q.stable;

endmodule // sfesv_sync

// ---- sfesv_fifo.sv ----
`timescale 1ns/1ps
module sfesv_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
    } sfesv_fifo_type;

    sfesv_fifo_type q;
    sfesv_fifo_type next_q;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////
    // pointer wrap written out so depth need not be a power of two
    always_comb begin
        push = in_valid_in && (q.cnt != CNT_FULL);
        pop = out_ready_in && (q.cnt != '0);
        next_q = q;
        if (push) begin
            next_q.mem[q.wp] = in_data_in;
            next_q.wp = (q.wp == PTR_LAST) ? '0 : q.wp + 1'b1;
        end
        if (pop) begin
            next_q.rp = (q.rp == PTR_LAST) ? '0 : q.rp + 1'b1;
        end
        if (push && !pop) begin
            next_q.cnt = q.cnt + 1'b1;
        end else if (pop && !push) begin
            next_q.cnt = q.cnt - 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign in_ready_out = (q.cnt != CNT_FULL);
    assign out_valid_out = (q.cnt != '0);
    assign out_data_out = q.mem[q.rp];

endmodule // sfesv_fifo

// ---- sfesv_top.sv ----
// Operation
// - size comes only from three length and two width presence inputs.
// - all lengths present: both widths 132, first width 141, none 165.
// - no widths: first two lengths 133, only first length 142.
// - no lengths: both widths 5, first width 14, nothing at all 128.
// - any other combination flags the size as undetectable.
// - sample sensors right after the cover closes.
// - start while cover open samples sensors at that moment.
// - bypass ignores sensors, assumes lengthwise, scans full largest area.
// - bypass with small sideways sheet detected stops feed and raises jam.
// - each video sample is 10-bit unsigned, 1024 levels.
// - odd and even pixel streams merge into one pixel-ordered stream.
// - white reference line refreshes stored white data before each original.
// - stored white applied per main-scan pixel position.
// - feeder scans swap red and blue.
// - black from masked elements each line, subtracted from every pixel.
// - per-pixel response and edge falloff compensated across the line.
// - red and blue line ends shifted to green; level is a setting.
// - line memory realigns colours four lines apart at unity.
// - line delay follows magnification ratio; the code clamps it at four lines from 113 percent up.
`timescale 1ns/1ps
module sfesv_top (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // size sensor pins {l3,l2,l1,w2,w1}
    input wire logic [4:0] SIZE_SENSE_IN,
    input wire logic COVER_CLOSED_IN,
    input wire logic START_KEY_IN,
    input wire logic REG_SMALL_SHEET_IN,
    // feed control
    input wire logic BYPASS_IN,
    input wire logic JAM_CLEAR_IN,
    input wire logic ADF_MODE_IN,
    // converter video
    input wire sfesv_pkg::sfesv_pix_type ODD_PIX_IN,
    input wire sfesv_pkg::sfesv_pix_type EVEN_PIX_IN,
    input wire logic PAIR_VALID_IN,
    input wire logic PAIR_MASKED_IN,
    output logic PAIR_READY_OUT,
    input wire logic LINE_START_IN,
    input wire logic WHITE_CAP_IN,
    // service settings
    input wire logic [1:0] DOT_ADJ_IN,
    input wire logic [8:0] MAG_PCT_IN,
    // size result
    output logic [7:0] SIZE_CODE_OUT,
    output logic SIZE_UNKNOWN_OUT,
    output logic SIZE_VALID_OUT,
    output logic FULL_AREA_OUT,
    output logic JAM_OUT,
    // corrected video
    output sfesv_pkg::sfesv_pix_type VID_OUT,
    output logic VID_VALID_OUT,
    input wire logic VID_READY_IN
);

    localparam int DP = sfesv_pkg::DEPTH;
    localparam int PX = sfesv_pkg::PIX;
    localparam int PW = sfesv_pkg::PIX_W;

    typedef struct packed {
        logic cover_q;
        logic start_q;
        sfesv_pkg::sfesv_size_type size;
        logic full_area;
        logic jam;
        logic pend;
        sfesv_pkg::sfesv_pix_type odd;
        logic [PW-1:0] px;
        logic [3:0] lp;
        sfesv_pkg::sfesv_pix_type black;
        sfesv_pkg::sfesv_pix_type prev;
        logic [PX-1:0][29:0] wref;
        logic [DP-1:0][PX-1:0][9:0] rmem;
        logic [DP-1:0][PX-1:0][9:0] gmem;
        logic ov;
        sfesv_pkg::sfesv_pix_type vid;
    } sfesv_top_type;

    sfesv_top_type q;
    sfesv_top_type next_q;

    logic [sfesv_pkg::SYNC_W-1:0] sy;
    logic [4:0] sns;
    logic cover_rise;
    logic start_rise;
    logic sample;
    logic go;
    logic take;
    logic proc;
    logic fifo_ready;
    logic edge_zone;
    logic [15:0] dly_raw;
    logic [2:0] dly;
    logic [3:0] rd_g;
    logic [3:0] rd_r;
    logic [PW-1:0] adj;
    sfesv_pkg::sfesv_pix_type src;
    sfesv_pkg::sfesv_pix_type sb;
    sfesv_pkg::sfesv_pix_type wn;
    sfesv_pkg::sfesv_pix_type sw;
    sfesv_pkg::sfesv_pix_type dp;
    sfesv_pkg::sfesv_pix_type wr;

    ////////////////////////////////////////////////////////////////////////
    // pins cross through three flops each
    sfesv_sync #(
        .W(sfesv_pkg::SYNC_W)
    ) u_sync (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .d_in({REG_SMALL_SHEET_IN, START_KEY_IN, COVER_CLOSED_IN, SIZE_SENSE_IN}),
        .q_out(sy)
    );

    ////////////////////////////////////////////////////////////////////////
    // table lookup; anything unlisted is undetectable
    function automatic sfesv_pkg::sfesv_size_type decode(input logic [4:0] p);
        sfesv_pkg::sfesv_size_type d;
        d.valid = 1'b1;
        d.unknown = 1'b0;
        case (p)
            sfesv_pkg::PAT_A3: d.code = sfesv_pkg::CODE_A3;
            sfesv_pkg::PAT_B4: d.code = sfesv_pkg::CODE_B4;
            sfesv_pkg::PAT_F4: d.code = sfesv_pkg::CODE_F4;
            sfesv_pkg::PAT_A4L: d.code = sfesv_pkg::CODE_A4L;
            sfesv_pkg::PAT_B5L: d.code = sfesv_pkg::CODE_B5L;
            sfesv_pkg::PAT_A4S: d.code = sfesv_pkg::CODE_A4S;
            sfesv_pkg::PAT_B5S: d.code = sfesv_pkg::CODE_B5S;
            sfesv_pkg::PAT_NONE: d.code = sfesv_pkg::CODE_A5;
            default: begin
                d.code = sfesv_pkg::CODE_UNDET;
                d.unknown = 1'b1;
            end
        endcase
        return d;
    endfunction

    // black subtraction floors at zero rather than wrapping
    function automatic logic [9:0] blk_sub(input logic [9:0] s, input logic [9:0] b);
        return (s > b) ? s - b : sfesv_pkg::VID_ZERO;
    endfunction

    // scale so the stored white reads full scale; a zero reference passes through
    function automatic logic [9:0] white_norm(input logic [9:0] s, input logic [9:0] w);
        logic [19:0] prod;
        logic [19:0] quo;
        prod = {10'h000, s} * {10'h000, sfesv_pkg::VID_MAX};
        quo = (w == sfesv_pkg::VID_ZERO) ? {10'h000, s} : prod / {10'h000, w};
        return (quo > {10'h000, sfesv_pkg::VID_MAX}) ? sfesv_pkg::VID_MAX : quo[9:0];
    endfunction

    // ring index k lines behind lp
    function automatic logic [3:0] back(input logic [3:0] lp, input logic [3:0] k);
        logic [4:0] sum;
        sum = {1'b0, lp} + sfesv_pkg::DEPTH_V - {1'b0, k};
        return (sum >= sfesv_pkg::DEPTH_V) ? 4'(sum - sfesv_pkg::DEPTH_V) : sum[3:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // size sampling events
    assign sns = sy[4:0];
    assign cover_rise = sy[sfesv_pkg::SY_COVER] && !q.cover_q;
    assign start_rise = sy[sfesv_pkg::SY_START] && !q.start_q;
    assign sample = cover_rise
        || (start_rise && !sy[sfesv_pkg::SY_COVER]);

    // pipeline advances when the output slot is free
    assign go = !q.ov || fifo_ready;
    assign PAIR_READY_OUT = go && !q.pend;
    assign take = PAIR_VALID_IN && PAIR_READY_OUT;
    assign proc = go && ((take && !PAIR_MASKED_IN) || q.pend);

    ////////////////////////////////////////////////////////////////////////
    // colour line delay rounded from the ratio; enlargement beyond max clamps
    always_comb begin
        dly_raw = ({7'h00, MAG_PCT_IN} * sfesv_pkg::GAP_LINES + sfesv_pkg::MAG_HALF)
            / sfesv_pkg::MAG_UNITY;
        dly = (dly_raw > {13'h0000, sfesv_pkg::MAX_DLY}) ? sfesv_pkg::MAX_DLY : dly_raw[2:0];
        rd_g = back(q.lp, {1'b0, dly});
        rd_r = back(q.lp, {dly, 1'b0});
        adj = {2'h0, DOT_ADJ_IN};
    end

    ////////////////////////////////////////////////////////////////////////
    // per-pixel correction chain
    always_comb begin
        src = q.pend ? q.odd : EVEN_PIX_IN;
        sb.r = blk_sub(src.r, q.black.r);
        sb.g = blk_sub(src.g, q.black.g);
        sb.b = blk_sub(src.b, q.black.b);
        wr = q.wref[q.px];
        wn.r = white_norm(sb.r, wr.r);
        wn.g = white_norm(sb.g, wr.g);
        wn.b = white_norm(sb.b, wr.b);
        // feeder optics reverse the colour order
        sw.r = ADF_MODE_IN ? wn.b : wn.r;
        sw.g = wn.g;
        sw.b = ADF_MODE_IN ? wn.r : wn.b;
        // line ends of red and blue take the previous dot to meet green
        edge_zone = (q.px < adj) || (q.px > (sfesv_pkg::PIX_LAST - adj));
        dp.r = edge_zone ? q.prev.r : sw.r;
        dp.g = sw.g;
        dp.b = edge_zone ? q.prev.b : sw.b;
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_q = q;
        next_q.cover_q = sy[sfesv_pkg::SY_COVER];
        next_q.start_q = sy[sfesv_pkg::SY_START];
        // bypass overrides the sensors; otherwise hold until a sample
        if (BYPASS_IN) begin
            next_q.size.code = sfesv_pkg::CODE_A3;
            next_q.size.unknown = 1'b0;
            next_q.size.valid = 1'b1;
            next_q.full_area = 1'b1;
        end else if (sample) begin
            next_q.size = decode(sns);
            next_q.full_area = 1'b0;
        end
        // set wins over clear
        if (BYPASS_IN && sy[sfesv_pkg::SY_SMALL]) begin
            next_q.jam = 1'b1;
        end else if (JAM_CLEAR_IN) begin
            next_q.jam = 1'b0;
        end
        // line start restarts position and steps the ring
        if (LINE_START_IN) begin
            next_q.px = '0;
            next_q.lp = (q.lp == sfesv_pkg::LP_LAST) ? 4'h0 : q.lp + 4'h1;
        end
        // masked pairs only refresh the black level of this line
        if (take && PAIR_MASKED_IN) begin
            next_q.black = EVEN_PIX_IN;
        end
        if (take && !PAIR_MASKED_IN) begin
            next_q.pend = 1'b1;
            next_q.odd = ODD_PIX_IN;
        end else if (go && q.pend) begin
            next_q.pend = 1'b0;
        end
        if (go) begin
            next_q.ov = proc;
        end
        if (proc) begin
            if (WHITE_CAP_IN) begin
                next_q.wref[q.px] = sb;
            end
            next_q.prev = sw;
            next_q.rmem[q.lp][q.px] = dp.r;
            next_q.gmem[q.lp][q.px] = dp.g;
            // first colour read waits two gaps, green one, blue none
            next_q.vid.r = (dly == 3'h0) ? dp.r : q.rmem[rd_r][q.px];
            next_q.vid.g = (dly == 3'h0) ? dp.g : q.gmem[rd_g][q.px];
            next_q.vid.b = dp.b;
            if (!LINE_START_IN && (q.px != sfesv_pkg::PIX_LAST)) begin
                next_q.px = q.px + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
        if (SYS_RST_IN) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output buffer; a stalled sink backs up to the pair handshake
    sfesv_fifo #(
        .WIDTH($bits(sfesv_pkg::sfesv_pix_type)),
        .DEPTH(sfesv_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_in(CLK_IN),
        .rst_in(SYS_RST_IN),
        .in_valid_in(q.ov),
        .in_ready_out(fifo_ready),
        .in_data_in(q.vid),
        .out_valid_out(VID_VALID_OUT),
        .out_ready_in(VID_READY_IN),
        .out_data_out(VID_OUT)
    );

    // size and feed outputs straight from flops
    assign SIZE_CODE_OUT = q.size.code;
    assign SIZE_UNKNOWN_OUT = q.size.unknown;
    assign SIZE_VALID_OUT = q.size.valid;
    assign FULL_AREA_OUT = q.full_area;
    assign JAM_OUT = q.jam;

endmodule // sfesv_top

// ---- sfesv_top_props.sv ----
`timescale 1ns/1ps
module sfesv_top_props (
    // clock and reset
    input wire logic CLK_IN,
    input wire logic SYS_RST_IN,
    // size side
    input wire logic COVER_CLOSED_IN,
    input wire logic START_KEY_IN,
    input wire logic REG_SMALL_SHEET_IN,
    input wire logic BYPASS_IN,
    input wire logic JAM_CLEAR_IN,
    input wire logic [7:0] SIZE_CODE_OUT,
    input wire logic SIZE_UNKNOWN_OUT,
    input wire logic SIZE_VALID_OUT,
    input wire logic FULL_AREA_OUT,
    input wire logic JAM_OUT,
    // video side
    input wire logic PAIR_VALID_IN,
    input wire logic PAIR_MASKED_IN,
    input wire logic PAIR_READY_OUT,
    input wire sfesv_pkg::sfesv_pix_type VID_OUT,
    input wire logic VID_VALID_OUT,
    input wire logic VID_READY_IN
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SYS_RST_IN);

    // six quiet cycles outlast the three-flop pin synchroniser
    sequence s_quiet;
        (!BYPASS_IN && !START_KEY_IN && $stable(COVER_CLOSED_IN))[*6];
    endsequence
    sequence s_small_bypass;
        (BYPASS_IN && REG_SMALL_SHEET_IN)[*6];
    endsequence
    sequence s_take;
        PAIR_VALID_IN && PAIR_READY_OUT && !PAIR_MASKED_IN;
    endsequence

    ////////////////////////////////////////////////////////////
    // size result
    a_bypass_forces: assert property (BYPASS_IN |=> SIZE_CODE_OUT == 8'h84 && !SIZE_UNKNOWN_OUT
        && FULL_AREA_OUT && SIZE_VALID_OUT) else $error("bypass did not force full area");
    a_jam_raise: assert property (s_small_bypass |=> JAM_OUT) else $error("jam not raised");
    a_jam_sticky: assert property (JAM_OUT && !JAM_CLEAR_IN |=> JAM_OUT) else $error("jam dropped");
    a_jam_cause: assert property ($rose(JAM_OUT) |-> $past(BYPASS_IN)) else $error("jam without bypass");
    a_size_hold: assert property (s_quiet |=> $stable(SIZE_CODE_OUT) && $stable(SIZE_UNKNOWN_OUT))
        else $error("size changed with no event");
    a_unknown_zero: assert property (SIZE_UNKNOWN_OUT |-> SIZE_CODE_OUT == 8'h00)
        else $error("undetectable with nonzero code");
    a_valid_keep: assert property (SIZE_VALID_OUT |=> SIZE_VALID_OUT) else $error("size valid fell");
    // video stream
    a_pair_split: assert property (s_take |=> !PAIR_READY_OUT) else $error("odd half not held");
    a_take_latency: assert property (s_take |-> ##2 VID_VALID_OUT) else $error("pixel late");
    a_out_hold: assert property (VID_VALID_OUT && !VID_READY_IN |=> VID_VALID_OUT && $stable(VID_OUT))
        else $error("output moved while stalled");
endmodule // sfesv_top_props

bind sfesv_top sfesv_top_props i_sfesv_top_props (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .COVER_CLOSED_IN(COVER_CLOSED_IN), .START_KEY_IN(START_KEY_IN), .REG_SMALL_SHEET_IN(REG_SMALL_SHEET_IN),
    .BYPASS_IN(BYPASS_IN), .JAM_CLEAR_IN(JAM_CLEAR_IN), .SIZE_CODE_OUT(SIZE_CODE_OUT),
    .SIZE_UNKNOWN_OUT(SIZE_UNKNOWN_OUT), .SIZE_VALID_OUT(SIZE_VALID_OUT), .FULL_AREA_OUT(FULL_AREA_OUT),
    .JAM_OUT(JAM_OUT), .PAIR_VALID_IN(PAIR_VALID_IN), .PAIR_MASKED_IN(PAIR_MASKED_IN),
    .PAIR_READY_OUT(PAIR_READY_OUT), .VID_OUT(VID_OUT), .VID_VALID_OUT(VID_VALID_OUT),
    .VID_READY_IN(VID_READY_IN));

// ---- sfesv_sink.sv ----
`timescale 1ns/1ps
module sfesv_sink (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // bench command
    input wire logic stall_in,
    // stream
    output logic ready_out
);
    // ready wanders so the fifo drains unevenly; stall holds it off to fill the fifo
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= !stall_in && ($urandom % 4 != 0);
        end
    end
endmodule // sfesv_sink

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    logic CLK_IN = 1'b0;
    logic SYS_RST_IN = 1'b1;
    logic [4:0] SIZE_SENSE_IN = 5'h00;
    logic COVER_CLOSED_IN = 0, START_KEY_IN = 0, REG_SMALL_SHEET_IN = 0, BYPASS_IN = 0, JAM_CLEAR_IN = 0;
    logic ADF_MODE_IN = 0, PAIR_VALID_IN = 0, PAIR_MASKED_IN = 0, LINE_START_IN = 0, WHITE_CAP_IN = 0, stall = 0;
    sfesv_pkg::sfesv_pix_type ODD_PIX_IN = '0, EVEN_PIX_IN = '0, VID_OUT;
    logic PAIR_READY_OUT, SIZE_UNKNOWN_OUT, SIZE_VALID_OUT, FULL_AREA_OUT, JAM_OUT, VID_VALID_OUT, VID_READY_IN;
    logic [7:0] SIZE_CODE_OUT;
    logic [30:0] exp_e;
    logic [30:0] expq [$];
    int miscompares = 0, n_tests = 0, cycles = 0;
    int white [16][3];
    int blk [3];
    logic [1:0] dot_adj = 2'h0;
    logic [8:0] mag = 9'h000;
    logic [29:0] prv = '0;

    always #5 CLK_IN = ~CLK_IN;

    // magnification kept low so the line delay rounds to zero: ring history is not modelled here
    sfesv_top i_sfesv_top (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SIZE_SENSE_IN(SIZE_SENSE_IN),
        .COVER_CLOSED_IN(COVER_CLOSED_IN), .START_KEY_IN(START_KEY_IN), .REG_SMALL_SHEET_IN(REG_SMALL_SHEET_IN),
        .BYPASS_IN(BYPASS_IN), .JAM_CLEAR_IN(JAM_CLEAR_IN), .ADF_MODE_IN(ADF_MODE_IN), .ODD_PIX_IN(ODD_PIX_IN),
        .EVEN_PIX_IN(EVEN_PIX_IN), .PAIR_VALID_IN(PAIR_VALID_IN), .PAIR_MASKED_IN(PAIR_MASKED_IN),
        .PAIR_READY_OUT(PAIR_READY_OUT), .LINE_START_IN(LINE_START_IN), .WHITE_CAP_IN(WHITE_CAP_IN),
        .DOT_ADJ_IN(dot_adj), .MAG_PCT_IN(mag), .SIZE_CODE_OUT(SIZE_CODE_OUT), .SIZE_UNKNOWN_OUT(SIZE_UNKNOWN_OUT),
        .SIZE_VALID_OUT(SIZE_VALID_OUT), .FULL_AREA_OUT(FULL_AREA_OUT), .JAM_OUT(JAM_OUT), .VID_OUT(VID_OUT),
        .VID_VALID_OUT(VID_VALID_OUT), .VID_READY_IN(VID_READY_IN));
    sfesv_sink i_sfesv_sink (.clk_in(CLK_IN), .rst_in(SYS_RST_IN), .stall_in(stall), .ready_out(VID_READY_IN));

    ////////////////////////////////////////////////////////////
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // {unknown, code}; 256 marks an undecodable pattern
    function automatic int size_exp(input int p);
        case (p)
            31: return 132;
            29: return 141;
            28: return 165;
            12: return 133;
            4: return 142;
            3: return 5;
            1: return 14;
            0: return 128;
            default: return 256;
        endcase
    endfunction

    // settle sensors, then sample by cover close or by start with the cover open
    task sample(input int p, input bit by_start);
        SIZE_SENSE_IN = p[4:0];
        COVER_CLOSED_IN = 0;
        repeat (6) @(negedge CLK_IN);
        if (by_start) START_KEY_IN = 1;
        else COVER_CLOSED_IN = 1;
        repeat (6) @(negedge CLK_IN);
        START_KEY_IN = 0;
        repeat (2) @(negedge CLK_IN);
        check("size", {23'h0, SIZE_UNKNOWN_OUT, SIZE_CODE_OUT}, size_exp(p));
    endtask

    // enters and leaves at a falling edge; valid stays up for the caller to drop
    task send_pair(input sfesv_pkg::sfesv_pix_type ev, input sfesv_pkg::sfesv_pix_type od, input bit masked);
        EVEN_PIX_IN = ev;
        ODD_PIX_IN = od;
        PAIR_MASKED_IN = masked;
        PAIR_VALID_IN = 1;
        while (PAIR_READY_OUT !== 1'b1) @(negedge CLK_IN);
        @(negedge CLK_IN);
    endtask

    // reference pixel: black removed, white normalised, optional red/blue exchange, end dots repeated
    task push_px(input int px, input logic [29:0] s, input bit cap, input bit adf);
        int v;
        int o;
        logic [9:0] r [3];
        logic [29:0] cur;
        for (int c = 0; c < 3; c++) begin
            v = int'(s[10*c +: 10]) - blk[c];
            if (v < 0) v = 0;
            // a freshly captured white only applies from the next line
            o = (white[px][c] == 0) ? v : v * 1023 / white[px][c];
            if (cap) white[px][c] = v;
            if (o > 1023) o = 1023;
            r[c] = o[9:0];
        end
        cur = adf ? {r[0], r[1], r[2]} : {r[2], r[1], r[0]};
        if (px < dot_adj || px > 15 - dot_adj) expq.push_back({!cap, prv[29:20], cur[19:10], prv[9:0]});
        else expq.push_back({!cap, cur});
        prv = cur;
    endtask

    // one line: start pulse, one masked black pair, eight active pairs
    task do_line(input bit cap, input bit adf);
        sfesv_pkg::sfesv_pix_type ev;
        sfesv_pkg::sfesv_pix_type od;
        PAIR_VALID_IN = 0;
        while (PAIR_READY_OUT !== 1'b1) @(negedge CLK_IN);
        LINE_START_IN = 1;
        WHITE_CAP_IN = cap;
        ADF_MODE_IN = adf;
        dot_adj = adf ? 2'($urandom % 3 + 1) : 2'h0;
        @(negedge CLK_IN);
        LINE_START_IN = 0;
        for (int c = 0; c < 3; c++) blk[c] = $urandom % 64;
        ev = {10'(blk[2]), 10'(blk[1]), 10'(blk[0])};
        send_pair(ev, 30'($urandom), 1);
        for (int k = 0; k < 8; k++) begin
            ev = cap ? {10'(600 + $urandom % 400), 10'(600 + $urandom % 400), 10'(600 + $urandom % 400)}
                     : 30'($urandom);
            od = cap ? ev : 30'($urandom);
            push_px(2 * k, ev, cap, adf);
            push_px(2 * k + 1, od, cap, adf);
            send_pair(ev, od, 0);
        end
    endtask

    ////////////////////////////////////////////////////////////
    // every popped pixel against the model; white capture lines are not compared
    always @(negedge CLK_IN) begin
        if (!SYS_RST_IN && VID_VALID_OUT === 1'b1 && VID_READY_IN === 1'b1) begin
            if (expq.size() == 0) begin
                check("extra pixel", 32'h1, 32'h0);
            end else begin
                exp_e = expq.pop_front();
                if (exp_e[30]) check("pixel", VID_OUT, exp_e[29:0]);
            end
        end
    end

    // hang guard well above the several hundred cycles the run needs
    always @(posedge CLK_IN) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test;
        end
    end

    initial begin
        void'($urandom(57));
        mag = 9'($urandom % 13);
        repeat (6) @(negedge CLK_IN);
        SYS_RST_IN = 0;
        repeat (4) @(negedge CLK_IN);
        for (int i = 0; i < 32; i++) sample(i, i % 2);
        sample(31, 0);
        SIZE_SENSE_IN = 5'h00;
        START_KEY_IN = 1;
        repeat (3) @(negedge CLK_IN);
        START_KEY_IN = 0;
        repeat (8) @(negedge CLK_IN);
        check("size held", {SIZE_UNKNOWN_OUT, SIZE_CODE_OUT}, 9'h084);
        REG_SMALL_SHEET_IN = 1;
        repeat (8) @(negedge CLK_IN);
        check("jam no bypass", JAM_OUT, 1'b0);
        REG_SMALL_SHEET_IN = 0;
        // let the synchronised small-sheet level fall before bypass can see it
        repeat (6) @(negedge CLK_IN);
        BYPASS_IN = 1;
        repeat (6) @(negedge CLK_IN);
        check("bypass", {JAM_OUT, FULL_AREA_OUT, SIZE_UNKNOWN_OUT, SIZE_CODE_OUT}, 11'h284);
        REG_SMALL_SHEET_IN = 1;
        repeat (6) @(negedge CLK_IN);
        check("jam", JAM_OUT, 1'b1);
        REG_SMALL_SHEET_IN = 0;
        repeat (6) @(negedge CLK_IN);
        JAM_CLEAR_IN = 1;
        @(negedge CLK_IN);
        JAM_CLEAR_IN = 0;
        @(negedge CLK_IN);
        check("jam cleared", JAM_OUT, 1'b0);
        BYPASS_IN = 0;
        do_line(0, 0);
        do_line(1, 0);
        do_line(0, 1);
        // stall the sink from the start of a line so the fifo fills and pairs are refused
        fork
            begin
                stall = 1;
                repeat (30) @(negedge CLK_IN);
                check("refused", {VID_VALID_OUT, PAIR_READY_OUT}, 2'b10);
                stall = 0;
            end
        join_none
        do_line(0, 0);
        do_line(0, 1);
        PAIR_VALID_IN = 0;
        for (int n = 0; n < 300 && expq.size() > 0; n++) @(negedge CLK_IN);
        check("pixels left", expq.size(), 32'h0);
        end_of_test;
    end
endmodule // testbench
